// *** src/tms_status_page.sv ***
// Transmitter lower status page with latched flags and timed controls
`timescale 1ns/1ps
module tms_status_page
  import tms_pkg::*;
#(
  parameter int RESET_HOLD_CYCLES = MODULE_RESET_HOLD_CYCLES
)(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        scl_i,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe_o,
  input  wire logic [2:0]  dev_addr_i,
  input  wire logic        module_hard_reset_n_i,
  input  wire logic [11:0] loss_of_input_signal_i,
  input  wire logic [11:0] tx_fault_i,
  input  wire logic        monitor_data_valid_i,
  output logic [11:0]      channel_enable_o,
  output logic             interrupt_out_n_o,
  output logic             interrupt_out_oe_o
);

  import tms_pkg::*;

  tms_reg_if bus ();

  logic [28:0] pin_meta_reg, pin_sync_reg;
  logic [11:0] los_latched_reg, fault_latched_reg;
  logic [11:0] disable_reg, mask_los_reg, mask_flt_reg;
  logic [11:0] disable_app_reg, mask_los_app_reg, mask_flt_app_reg;
  logic [11:0] chan_en_reg, los_now, fault_now, los_clr, flt_clr;
  logic        int_static_reg, int_static_app_reg;
  logic        wrote_reg, reset_req_reg, reset_start_reg, reset_active_reg;
  logic        any_flag_d_reg, int_n_reg, int_oe_reg, sda_out_reg;
  logic        hard_reset_n, in_reset, any_flag, int_low;
  logic        apply_start, apply_done, pulse_busy, hold_done;
  logic [7:0]  summary;

  // Clear mask for a flag pair when its byte has been sent
  function automatic logic [11:0] flag_clear(
    input logic       rd,
    input logic [7:0] a,
    input logic [7:0] hi,
    input logic [7:0] lo
  );
    flag_clear = 12'h000;
    if (rd && a == hi)
      flag_clear[11:8] = 4'hF;
    if (rd && a == lo)
      flag_clear[7:0] = 8'hFF;
  endfunction : flag_clear

  // Byte write into a twelve-bit channel control pair
  function automatic logic [11:0] pair_write(
    input logic [11:0] old,
    input logic        wr,
    input logic [7:0]  a,
    input logic [7:0]  hi,
    input logic [7:0]  lo,
    input logic [7:0]  d
  );
    pair_write = old;
    if (wr && a == hi)
      pair_write[11:8] = d[3:0];
    if (wr && a == lo)
      pair_write[7:0] = d;
  endfunction : pair_write

  // Pins from outside pass two stages first
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      pin_meta_reg <= 29'h0000000;
      pin_sync_reg <= 29'h0000000;
    end
    else
    begin
      pin_meta_reg <= {module_hard_reset_n_i, monitor_data_valid_i,
                       dev_addr_i, tx_fault_i, loss_of_input_signal_i};
      pin_sync_reg <= pin_meta_reg;
    end
  end

  assign los_now      = pin_sync_reg[11:0];
  assign fault_now    = pin_sync_reg[23:12];
  assign hard_reset_n = pin_sync_reg[28];
  assign in_reset     = ~hard_reset_n | reset_active_reg;
  assign los_clr  = flag_clear(bus.rd_done, bus.addr,
                               ADDR_LOS_HI, ADDR_LOS_LO);
  assign flt_clr  = flag_clear(bus.rd_done, bus.addr,
                               ADDR_FAULT_HI, ADDR_FAULT_LO);

  tms_tws_slave u_slave (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .scl_i      (scl_i),
    .sda_i      (sda_i),
    .dev_addr_i (pin_sync_reg[26:24]),
    .inhibit_i  (~hard_reset_n),
    .sda_oe_o   (sda_oe_o),
    .bus        (bus.serial)
  );

  // Latched flags; a new event in the clearing cycle wins
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      los_latched_reg   <= 12'h000;
      fault_latched_reg <= 12'h000;
    end
    else if (in_reset)
    begin
      los_latched_reg   <= 12'h000;
      fault_latched_reg <= 12'h000;
    end
    else
    begin
      los_latched_reg   <= (los_latched_reg & ~los_clr) | los_now;
      fault_latched_reg <= (fault_latched_reg & ~flt_clr)
                           | fault_now;
    end
  end

  // Host-written controls; volatile ones fall back on any reset
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      disable_reg    <= CONTROL_RESET;
      mask_los_reg   <= CONTROL_RESET;
      mask_flt_reg   <= CONTROL_RESET;
      int_static_reg <= INT_STATIC_RESET;
      reset_req_reg  <= 1'b0;
      wrote_reg      <= 1'b0;
    end
    else if (in_reset)
    begin
      // Non-volatile mode bit deliberately untouched here
      disable_reg   <= CONTROL_RESET;
      mask_los_reg  <= CONTROL_RESET;
      mask_flt_reg  <= CONTROL_RESET;
      reset_req_reg <= 1'b0;
      wrote_reg     <= 1'b0;
    end
    else
    begin
      disable_reg  <= pair_write(disable_reg, bus.wr_en, bus.addr,
                       ADDR_DISABLE_HI, ADDR_DISABLE_LO, bus.wdata);
      mask_los_reg <= pair_write(mask_los_reg, bus.wr_en, bus.addr,
                       ADDR_MASK_LOS_HI, ADDR_MASK_LOS_LO, bus.wdata);
      mask_flt_reg <= pair_write(mask_flt_reg, bus.wr_en, bus.addr,
                       ADDR_MASK_FLT_HI, ADDR_MASK_FLT_LO, bus.wdata);
      if (bus.wr_en && bus.addr == ADDR_INT_MODE)
        int_static_reg <= bus.wdata[INT_STATIC_BIT];
      if (bus.stop)
        reset_req_reg <= 1'b0;
      else if (bus.wr_en && bus.addr == ADDR_MODULE_RESET)
        reset_req_reg <= bus.wdata[MODULE_RESET_BIT];
      if (bus.stop)
        wrote_reg <= 1'b0;
      else if (bus.wr_en)
        wrote_reg <= 1'b1;
    end
  end

  // Interval starts at the stop of a write transaction
  assign apply_start = bus.stop & wrote_reg & ~in_reset;

  tms_delay_timer #(.CYCLES(CONTROL_APPLY_CYCLES)) u_apply (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .start_i (apply_start),
    .busy_o  (),
    .done_o  (apply_done)
  );

  // Staged values take effect after the transition window
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      disable_app_reg    <= CONTROL_RESET;
      mask_los_app_reg   <= CONTROL_RESET;
      mask_flt_app_reg   <= CONTROL_RESET;
      int_static_app_reg <= INT_STATIC_RESET;
    end
    else if (in_reset)
    begin
      disable_app_reg  <= CONTROL_RESET;
      mask_los_app_reg <= CONTROL_RESET;
      mask_flt_app_reg <= CONTROL_RESET;
    end
    else if (apply_done)
    begin
      disable_app_reg    <= disable_reg;
      mask_los_app_reg   <= mask_los_reg;
      mask_flt_app_reg   <= mask_flt_reg;
      int_static_app_reg <= int_static_reg;
    end
  end

  // Module register reset: begins two cycles after the stop strobe, held a while
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      reset_start_reg  <= 1'b0;
      reset_active_reg <= 1'b0;
    end
    else
    begin
      reset_start_reg <= bus.stop & reset_req_reg & hard_reset_n;
      if (reset_start_reg)
        reset_active_reg <= 1'b1;
      else if (hold_done)
        reset_active_reg <= 1'b0;
    end
  end

  tms_delay_timer #(.CYCLES(RESET_HOLD_CYCLES)) u_hold (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .start_i (reset_start_reg),
    .busy_o  (),
    .done_o  (hold_done)
  );

  // Outputs off for fault or signal loss, or while disabled or reset
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      chan_en_reg <= 12'h000;
    else if (in_reset)
      chan_en_reg <= 12'h000;
    else
      chan_en_reg <= ~disable_app_reg & ~fault_now & ~los_now;
  end

  assign any_flag = |((los_latched_reg & ~mask_los_app_reg)
                    | (fault_latched_reg & ~mask_flt_app_reg));

  // Pulse mode fires once each time the unmasked flags go from none set to some set
  tms_delay_timer #(.CYCLES(INT_PULSE_CYCLES)) u_pulse (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .start_i (any_flag & ~any_flag_d_reg & ~int_static_app_reg),
    .busy_o  (pulse_busy),
    .done_o  ()
  );

  assign int_low = int_static_app_reg ? any_flag : pulse_busy;

  // Open-drain interrupt and data pins, driven only when low
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      any_flag_d_reg <= 1'b0;
      int_n_reg      <= 1'b1;
      int_oe_reg     <= 1'b0;
      sda_out_reg    <= 1'b0;
    end
    else
    begin
      any_flag_d_reg <= any_flag;
      int_n_reg      <= ~int_low;
      int_oe_reg     <= int_low;
      sda_out_reg    <= 1'b0;
    end
  end

  // Summary byte built from latched flag state, monitor data valid and reset state
  always_comb
  begin
    summary                    = 8'h00;
    summary[SUM_FAULT_BIT]     = |fault_latched_reg;
    summary[SUM_LOS_BIT]       = |los_latched_reg;
    summary[SUM_INT_BIT]       = any_flag;
    summary[SUM_NOT_READY_BIT] = ~pin_sync_reg[27] | in_reset;
  end

  // Read data; unmapped bytes read as zero
  always_comb
  begin
    unique case (bus.addr)
      ADDR_TYPE_ID:      bus.rdata = TYPE_ID_VALUE;
      ADDR_SUMMARY:      bus.rdata = summary;
      ADDR_LOS_HI:       bus.rdata = {4'h0, los_latched_reg[11:8]};
      ADDR_LOS_LO:       bus.rdata = los_latched_reg[7:0];
      ADDR_FAULT_HI:     bus.rdata = {4'h0, fault_latched_reg[11:8]};
      ADDR_FAULT_LO:     bus.rdata = fault_latched_reg[7:0];
      ADDR_DISABLE_HI:   bus.rdata = {4'h0, disable_reg[11:8]};
      ADDR_DISABLE_LO:   bus.rdata = disable_reg[7:0];
      ADDR_INT_MODE:     bus.rdata = {7'h00, int_static_reg};
      ADDR_MASK_LOS_HI:  bus.rdata = {4'h0, mask_los_reg[11:8]};
      ADDR_MASK_LOS_LO:  bus.rdata = mask_los_reg[7:0];
      ADDR_MASK_FLT_HI:  bus.rdata = {4'h0, mask_flt_reg[11:8]};
      ADDR_MASK_FLT_LO:  bus.rdata = mask_flt_reg[7:0];
      default:           bus.rdata = 8'h00;
    endcase
  end

  assign channel_enable_o   = chan_en_reg;
  assign interrupt_out_n_o  = int_n_reg;
  assign interrupt_out_oe_o = int_oe_reg;
  assign sda_o              = sda_out_reg;

endmodule : tms_status_page

// *** src/tms_pkg.sv ***
// Shared constants and types for the transmitter status page block
package tms_pkg;

  // Clock and channel geometry
  localparam int          CLK_PERIOD_NS     = 10;
  localparam int          NUM_CHANNELS      = 12;
  localparam int          TIMER_WIDTH       = 24;

  // Lower page byte offsets
  localparam logic [7:0]  ADDR_TYPE_ID      = 8'h00;
  localparam logic [7:0]  ADDR_RESERVED_ONE = 8'h01;
  localparam logic [7:0]  ADDR_SUMMARY      = 8'h02;
  localparam logic [7:0]  ADDR_LOS_HI       = 8'h09;
  localparam logic [7:0]  ADDR_LOS_LO       = 8'h0A;
  localparam logic [7:0]  ADDR_FAULT_HI     = 8'h0B;
  localparam logic [7:0]  ADDR_FAULT_LO     = 8'h0C;
  localparam logic [7:0]  ADDR_DISABLE_HI   = 8'h56;
  localparam logic [7:0]  ADDR_DISABLE_LO   = 8'h57;
  localparam logic [7:0]  ADDR_MODULE_RESET = 8'h5B;
  localparam logic [7:0]  ADDR_INT_MODE     = 8'h5C;
  localparam logic [7:0]  ADDR_MASK_LOS_HI  = 8'h64;
  localparam logic [7:0]  ADDR_MASK_LOS_LO  = 8'h65;
  localparam logic [7:0]  ADDR_MASK_FLT_HI  = 8'h66;
  localparam logic [7:0]  ADDR_MASK_FLT_LO  = 8'h67;

  // Field positions
  localparam int          SUM_FAULT_BIT     = 3;
  localparam int          SUM_LOS_BIT       = 2;
  localparam int          SUM_INT_BIT       = 1;
  localparam int          SUM_NOT_READY_BIT = 0;
  localparam int          MODULE_RESET_BIT  = 0;
  localparam int          INT_STATIC_BIT    = 0;

  // Reset values; type code is arbitrary
  localparam logic [7:0]  TYPE_ID_VALUE     = 8'h3C;
  localparam logic [11:0] CONTROL_RESET     = 12'h000;
  localparam logic        INT_STATIC_RESET  = 1'b0;

  // Serial slave address high nibble
  localparam logic [3:0]  TWS_ADDR_BASE     = 4'h5;

  // Timing in printed units and derived cycle counts
  localparam int CONTROL_TRANSITION_US = 10;
  localparam int CONTROL_APPLY_CYCLES  =
    (CONTROL_TRANSITION_US * 1000) / CLK_PERIOD_NS;
  localparam int INT_PULSE_US          = 5;
  localparam int INT_PULSE_CYCLES      =
    (INT_PULSE_US * 1000) / CLK_PERIOD_NS;
  localparam int MODULE_RESET_HOLD_MS  = 10;
  localparam int MODULE_RESET_HOLD_CYCLES =
    (MODULE_RESET_HOLD_MS * 1000000) / CLK_PERIOD_NS;

  // Serial slave states
  typedef enum logic [2:0] {
    TWS_IDLE      = 3'b000,
    TWS_ADDR      = 3'b001,
    TWS_ADDR_ACK  = 3'b010,
    TWS_WRITE     = 3'b011,
    TWS_WRITE_ACK = 3'b100,
    TWS_READ      = 3'b101,
    TWS_READ_ACK  = 3'b110
  } tms_tws_state_type;

endpackage : tms_pkg

// *** src/tms_reg_if.sv ***
// Byte access carrier between the serial slave and the register bank
`timescale 1ns/1ps
interface tms_reg_if;
  logic       wr_en;
  logic       rd_done;
  logic       stop;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;

  modport serial (output wr_en, output rd_done, output stop,
                  output addr, output wdata, input rdata);
  modport bank   (input wr_en, input rd_done, input stop,
                  input addr, input wdata, output rdata);
endinterface : tms_reg_if

// *** src/tms_delay_timer.sv ***
// Down-counter that times a fixed interval from a start pulse
`timescale 1ns/1ps
module tms_delay_timer
  import tms_pkg::*;
#(
  parameter int CYCLES = 1000
)(
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic start_i,
  output logic      busy_o,
  output logic      done_o
);

  logic [TIMER_WIDTH-1:0] count_reg;

  // A new start restarts the interval
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      count_reg <= '0;
    else if (start_i)
      count_reg <= TIMER_WIDTH'(CYCLES);
    else if (count_reg != '0)
      count_reg <= count_reg - 1'b1;
  end

  assign busy_o = (count_reg != '0);
  assign done_o = (count_reg == TIMER_WIDTH'(1));

endmodule : tms_delay_timer

// *** src/tms_tws_slave.sv ***
// Two-wire serial slave giving byte access to the lower status page
`timescale 1ns/1ps
module tms_tws_slave
  import tms_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  input  wire logic [2:0] dev_addr_i,
  input  wire logic       inhibit_i,
  output logic            sda_oe_o,
  tms_reg_if.serial       bus
);

  tms_tws_state_type state_reg;
  logic [1:0] line_meta_reg, line_sync_reg, line_prev_reg;
  logic [3:0] bit_cnt_reg;
  logic [7:0] shift_reg, tx_reg, ptr_reg, wdata_reg;
  logic       rw_reg, ack_cont_reg, oe_reg, ptr_pend_reg, addressed_reg;
  logic       wr_en_reg, rd_done_reg, stop_reg;
  logic       scl, sda, rise, fall, start_det, stop_det, match, byte_in;

  // Two stages on the pins before any logic looks at them
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      line_meta_reg <= 2'h3;
      line_sync_reg <= 2'h3;
      line_prev_reg <= 2'h3;
    end
    else
    begin
      line_meta_reg <= {scl_i, sda_i};
      line_sync_reg <= line_meta_reg;
      line_prev_reg <= line_sync_reg;
    end
  end

  assign scl       = line_sync_reg[1];
  assign sda       = line_sync_reg[0];
  assign rise      = scl & ~line_prev_reg[1];
  assign fall      = ~scl & line_prev_reg[1];
  assign start_det = scl & line_prev_reg[1] & line_prev_reg[0] & ~sda;
  assign stop_det  = scl & line_prev_reg[1] & ~line_prev_reg[0] & sda;
  assign match     = (shift_reg[7:1] == {TWS_ADDR_BASE, dev_addr_i});
  assign byte_in   = fall && (bit_cnt_reg == 4'h8);

  // Bit-level protocol sequencer
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      state_reg    <= TWS_IDLE;
      bit_cnt_reg  <= 4'h0;
      shift_reg    <= 8'h00;
      tx_reg       <= 8'h00;
      rw_reg       <= 1'b0;
      ack_cont_reg <= 1'b0;
      oe_reg       <= 1'b0;
    end
    else if (inhibit_i)
    begin
      state_reg <= TWS_IDLE;
      oe_reg    <= 1'b0;
    end
    else if (start_det)
    begin
      state_reg   <= TWS_ADDR;
      bit_cnt_reg <= 4'h0;
      oe_reg      <= 1'b0;
    end
    else if (stop_det)
    begin
      state_reg <= TWS_IDLE;
      oe_reg    <= 1'b0;
    end
    else
    begin
      unique case (state_reg)
        TWS_IDLE: ;
        TWS_ADDR, TWS_WRITE:
          if (rise)
          begin
            shift_reg   <= {shift_reg[6:0], sda};
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
          end
          else if (byte_in)
          begin
            // Address mismatch drops out until the next start
            if (state_reg == TWS_WRITE || match)
            begin
              oe_reg    <= 1'b1;
              state_reg <= (state_reg == TWS_ADDR) ? TWS_ADDR_ACK
                                                   : TWS_WRITE_ACK;
            end
            else
              state_reg <= TWS_IDLE;
            if (state_reg == TWS_ADDR)
              rw_reg <= shift_reg[0];
          end
        TWS_ADDR_ACK, TWS_WRITE_ACK:
          if (fall)
          begin
            bit_cnt_reg <= 4'h0;
            if (state_reg == TWS_ADDR_ACK && rw_reg)
            begin
              tx_reg    <= bus.rdata;
              oe_reg    <= ~bus.rdata[7];
              state_reg <= TWS_READ;
            end
            else
            begin
              oe_reg    <= 1'b0;
              state_reg <= TWS_WRITE;
            end
          end
        TWS_READ:
          if (rise)
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
          else if (byte_in)
          begin
            oe_reg    <= 1'b0;
            state_reg <= TWS_READ_ACK;
          end
          else if (fall)
          begin
            tx_reg <= {tx_reg[6:0], 1'b0};
            oe_reg <= ~tx_reg[6];
          end
        TWS_READ_ACK:
          if (rise)
            ack_cont_reg <= ~sda;
          else if (fall)
          begin
            bit_cnt_reg <= 4'h0;
            if (ack_cont_reg)
            begin
              tx_reg    <= bus.rdata;
              oe_reg    <= ~bus.rdata[7];
              state_reg <= TWS_READ;
            end
            else
              state_reg <= TWS_IDLE;
          end
        default:
          state_reg <= TWS_IDLE;
      endcase
    end
  end

  // Byte events, pointer and stop reporting toward the bank
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      ptr_reg       <= 8'h00;
      ptr_pend_reg  <= 1'b0;
      addressed_reg <= 1'b0;
      wdata_reg     <= 8'h00;
      wr_en_reg     <= 1'b0;
      rd_done_reg   <= 1'b0;
      stop_reg      <= 1'b0;
    end
    else
    begin
      wr_en_reg   <= 1'b0;
      rd_done_reg <= 1'b0;
      stop_reg    <= stop_det & addressed_reg;
      if (stop_det || start_det || inhibit_i)
        addressed_reg <= 1'b0;
      else if (state_reg == TWS_ADDR && byte_in && match)
        addressed_reg <= 1'b1;
      if (state_reg == TWS_ADDR_ACK && fall && !rw_reg)
        ptr_pend_reg <= 1'b1;
      else if (state_reg == TWS_WRITE && byte_in)
      begin
        ptr_pend_reg <= 1'b0;
        wdata_reg    <= shift_reg;
        wr_en_reg    <= ~ptr_pend_reg;
        if (ptr_pend_reg)
          ptr_reg <= shift_reg;
      end
      else if (state_reg == TWS_READ && byte_in)
        rd_done_reg <= 1'b1;
      else if (wr_en_reg || rd_done_reg)
        ptr_reg <= ptr_reg + 8'h01;
    end
  end

  assign sda_oe_o    = oe_reg;
  assign bus.wr_en   = wr_en_reg;
  assign bus.rd_done = rd_done_reg;
  assign bus.stop    = stop_reg;
  assign bus.addr    = ptr_reg;
  assign bus.wdata   = wdata_reg;

endmodule : tms_tws_slave

// *** src/tms_status_page_unused.sv ***
// Holds no logic; each module of the block has a file of its own

// *** tb/tms_status_page_chk.sv ***
// Pin-level checks on the status page
`timescale 1ns/1ps
module tms_status_page_chk
  import tms_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        scl_i,
  input  wire logic        sda_oe_o,
  input  wire logic        module_hard_reset_n_i,
  input  wire logic [11:0] loss_of_input_signal_i,
  input  wire logic [11:0] tx_fault_i,
  input  wire logic [11:0] channel_enable_o,
  input  wire logic        interrupt_out_n_o,
  input  wire logic        interrupt_out_oe_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  oe_mirror_a:
    assert property (interrupt_out_oe_o == !interrupt_out_n_o)
    else $error("interrupt enable not the inverse of level");
  fault_off_a:
    assert property (!(|(tx_fault_i & $past(tx_fault_i, 3) & channel_enable_o)))
    else $error("faulted channel still on");
  loss_off_a:
    assert property (loss_of_input_signal_i[9] [*4] |-> !channel_enable_o[9])
    else $error("signal loss channel not squelched");
  fault_irq_a:
    assert property (disable iff (rst_i || !module_hard_reset_n_i)
      $rose(tx_fault_i[11]) |-> ##[1:8] !interrupt_out_n_o)
    else $error("fault did not raise the interrupt");
  irq_hold_a:
    assert property ($fell(interrupt_out_n_o) |=> !interrupt_out_n_o [*8])
    else $error("interrupt released too early");
  hard_off_a:
    assert property (!module_hard_reset_n_i [*5] |-> !sda_oe_o)
    else $error("data line driven during hard reset");
  hard_end_a:
    assert property (!module_hard_reset_n_i [*5] ##1 module_hard_reset_n_i
      |-> channel_enable_o == 12'h000)
    else $error("channels on during hard reset");
  sda_steady_a:
    assert property ($changed(sda_oe_o) |-> !scl_i)
    else $error("data changed while clock high");
  cover property ($fell(interrupt_out_n_o));
  cover property (!module_hard_reset_n_i [*5]);
  cover property ($rose(sda_oe_o));
endmodule : tms_status_page_chk

bind tms_status_page tms_status_page_chk tms_status_page_chk_inst (
  .clk_i, .rst_i, .scl_i, .sda_oe_o, .module_hard_reset_n_i,
  .loss_of_input_signal_i, .tx_fault_i, .channel_enable_o,
  .interrupt_out_n_o, .interrupt_out_oe_o
);

// *** tb/tms_host_model.sv ***
// Two-wire bus master standing in for the host
`timescale 1ns/1ps
module tms_host_model
  import tms_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       sda_oe_i,
  input  wire logic [2:0] dev_i,
  output logic            scl_o,
  output logic            sda_o
);
  logic       pull = 1'b0;
  logic       nak  = 1'b0;
  logic [7:0] q;
  // Pull-up: a released line reads high
  assign sda_o = !(pull || sda_oe_i);
  initial scl_o = 1'b1;
  task automatic hw(input int n);
    repeat (n) @(negedge clk_i);
  endtask : hw
  // Data moves in the low phase, sampled late in the high phase
  task automatic bit_io(input logic b, output logic r);
    pull = !b;
    hw(6);
    scl_o = 1'b1;
    hw(6);
    r = sda_o;
    scl_o = 1'b0;
    hw(2);
  endtask : bit_io
  task automatic xfer(input logic [7:0] d, input logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
      bit_io(d[i], q[i]);
    bit_io(1'b1, r);
    nak = nak | (ack & r);
  endtask : xfer
  task automatic start;
    pull = 1'b0;
    hw(6);
    scl_o = 1'b1;
    hw(6);
    pull = 1'b1;
    hw(6);
    scl_o = 1'b0;
    hw(2);
  endtask : start
  task automatic stop;
    pull = 1'b1;
    hw(6);
    scl_o = 1'b1;
    hw(6);
    pull = 1'b0;
    hw(6);
  endtask : stop
  // One transaction at a time; the bus stays otherwise idle
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    start;
    xfer({TWS_ADDR_BASE, dev_i, 1'b0}, 1'b1);
    xfer(a, 1'b1);
    xfer(d, 1'b1);
    stop;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    start;
    xfer({TWS_ADDR_BASE, dev_i, 1'b0}, 1'b1);
    xfer(a, 1'b1);
    start;
    xfer({TWS_ADDR_BASE, dev_i, 1'b1}, 1'b1);
    xfer(8'hFF, 1'b0);
    stop;
  endtask : rd
endmodule : tms_host_model

// *** tb/tb_tx_module_status_page_timing.sv ***
// Self-checking bench for the status page
`timescale 1ns/1ps
module tb_tx_module_status_page_timing;
  import tms_pkg::*;
  localparam int HOLD = 50;
  logic        clk_i  = 1'b0;
  logic        rst_i  = 1'b1;
  logic        hard_n = 1'b1;
  logic        mon    = 1'b0;
  logic [11:0] loss_of_input_signal    = 12'h000;
  logic [11:0] flt    = 12'h000;
  logic        scl_i;
  logic        sda_i;
  logic        sda_oe_o;
  logic        sda_o;
  logic        int_n;
  logic [11:0] ch_en;
  int          fail_count = 0;
  int          n_compared = 0;
  int          cycles     = 0;
  tms_status_page #(.RESET_HOLD_CYCLES(HOLD)) tms_status_page_inst (
    .clk_i, .rst_i, .scl_i, .sda_i, .sda_o, .sda_oe_o,
    .dev_addr_i(3'h2), .module_hard_reset_n_i(hard_n),
    .loss_of_input_signal_i(loss_of_input_signal), .tx_fault_i(flt),
    .monitor_data_valid_i(mon), .channel_enable_o(ch_en),
    .interrupt_out_n_o(int_n), .interrupt_out_oe_o());
  tms_host_model tms_host_model_inst (.clk_i, .sda_oe_i(sda_oe_o),
    .dev_i(3'h2), .scl_o(scl_i), .sda_o(sda_i));
  initial forever #5 clk_i = !clk_i;
  // Hang guard, far above the expected run
  always @(posedge clk_i)
  begin
    cycles <= cycles + 1;
    if (cycles == 80000)
    begin
      fail_count++;
      complete_run;
    end
  end
  task automatic tick(input int n);
    repeat (n) @(negedge clk_i);
  endtask : tick
  task automatic chk_pin(input logic [11:0] got, input logic [11:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      fail_count++;
      $display("unexpected value at %0t: %h not %h", $time, got, exp);
    end
  endtask : chk_pin
  task automatic chk_reg(input logic [7:0] a, input logic [7:0] exp);
    tms_host_model_inst.rd(a);
    chk_pin({4'h0, tms_host_model_inst.q}, {4'h0, exp});
  endtask : chk_reg
  // Write, then sit out the apply window
  task automatic put(input logic [7:0] a, input logic [7:0] d);
    tms_host_model_inst.wr(a, d);
    tick(CONTROL_APPLY_CYCLES + 4);
  endtask : put
  task automatic t_ident;
    chk_reg(ADDR_TYPE_ID, TYPE_ID_VALUE);
    chk_reg(ADDR_RESERVED_ONE, 8'h00);
    chk_reg(ADDR_SUMMARY, 8'h01);
    mon = 1'b1;
    tick(4);
    chk_reg(ADDR_SUMMARY, 8'h00);
  endtask : t_ident
  task automatic t_disable;
    put(ADDR_DISABLE_LO, 8'hFF);
    chk_pin(ch_en, 12'hF00);
    put(ADDR_DISABLE_LO, 8'h00);
    chk_pin(ch_en, 12'hFFF);
  endtask : t_disable
  task automatic t_los;
    loss_of_input_signal = 12'h204;
    tick(6);
    chk_pin(ch_en, 12'hDFB);
    chk_pin({11'h000, int_n}, 12'h000);
    loss_of_input_signal = 12'h000;
    tick(INT_PULSE_CYCLES + 8);
    chk_pin({11'h000, int_n}, 12'h001);
    chk_reg(ADDR_SUMMARY, 8'h06);
    chk_reg(ADDR_LOS_HI, 8'h02);
    chk_reg(ADDR_LOS_HI, 8'h00);
    chk_reg(ADDR_LOS_LO, 8'h04);
    chk_reg(ADDR_SUMMARY, 8'h00);
  endtask : t_los
  task automatic t_fault;
    put(ADDR_INT_MODE, 8'h01);
    flt = 12'h800;
    tick(8);
    chk_pin({11'h000, int_n}, 12'h000);
    chk_pin(ch_en, 12'h7FF);
    chk_reg(ADDR_FAULT_HI, 8'h08);
    chk_reg(ADDR_SUMMARY, 8'h0A);
    flt = 12'h000;
    chk_reg(ADDR_FAULT_HI, 8'h08);
    chk_reg(ADDR_FAULT_HI, 8'h00);
    tick(8);
    chk_pin({11'h000, int_n}, 12'h001);
  endtask : t_fault
  task automatic t_mask;
    put(ADDR_MASK_LOS_LO, 8'h01);
    loss_of_input_signal = 12'h001;
    tick(8);
    loss_of_input_signal = 12'h000;
    chk_pin({11'h000, int_n}, 12'h001);
    chk_reg(ADDR_LOS_LO, 8'h01);
    put(ADDR_MASK_LOS_LO, 8'h00);
    loss_of_input_signal = 12'h001;
    tick(8);
    loss_of_input_signal = 12'h000;
    chk_pin({11'h000, int_n}, 12'h000);
    chk_reg(ADDR_LOS_LO, 8'h01);
    tick(8);
    chk_pin({11'h000, int_n}, 12'h001);
    // Fault mask on channel 0; channel 11 stays free for the checker
    put(ADDR_MASK_FLT_LO, 8'h01);
    flt = 12'h001;
    tick(8);
    flt = 12'h000;
    chk_pin({11'h000, int_n}, 12'h001);
    chk_reg(ADDR_FAULT_LO, 8'h01);
  endtask : t_mask
  task automatic t_regreset;
    put(ADDR_DISABLE_HI, 8'h0F);
    chk_pin(ch_en, 12'h0FF);
    tms_host_model_inst.wr(ADDR_MODULE_RESET, 8'h01);
    tick(4);
    chk_pin(ch_en, 12'h000);
    tick(HOLD + 8);
    chk_pin(ch_en, 12'hFFF);
    chk_reg(ADDR_INT_MODE, 8'h01);
  endtask : t_regreset
  task automatic t_hard;
    loss_of_input_signal = 12'h100;
    tick(20);
    loss_of_input_signal = 12'h000;
    hard_n = 1'b0;
    tick(6);
    chk_pin(ch_en, 12'h000);
    hard_n = 1'b1;
    tick(6);
    chk_pin({11'h000, int_n}, 12'h001);
    chk_reg(ADDR_LOS_HI, 8'h00);
    chk_reg(ADDR_INT_MODE, 8'h01);
  endtask : t_hard
  task automatic complete_run;
    $display("compared %0d mismatched %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : complete_run
  // Reset for five cycles, then the scenarios in turn
  initial
  begin
    tick(5);
    rst_i = 1'b0;
    tick(8);
    t_ident;
    t_disable;
    t_los;
    t_fault;
    t_mask;
    t_regreset;
    t_hard;
    chk_pin({10'h000, sda_o, tms_host_model_inst.nak}, 12'h000);
    complete_run;
  end
endmodule : tb_tx_module_status_page_timing
